// ===== design/ucp_cell_port.v
// Contract
// - Transmit link signals timed by transmit clock.
// - Receive link signals timed by receive clock.
// - Accept transmit words only while enable low.
// - Deliver receive words only while enable low.
// - Transmit address 31 selects no port.
// - Receive address 0-30 valid, 31 null.
// - Transmit word up to sixteen bits accepted.
// - Check transmit parity over 8/16 bits.
// - Parity sense bit two selects odd/even.
// - Generate receive parity over 8/16 bits.
// - Receive parity odd/even per sense bit.
// - Mark first received word high, else low.
// - Receive data outputs are tri-statable.
// - Transmit available shows full or cell space.
// - Receive available shows empty or cell ready.
`timescale 1ns/1ns
`include "ucp_defines.vh"
module ucp_cell_port (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_mcs_n,
	input wire i_mwr_n,
	input wire i_moe_n,
	input wire [13:0] i_maddr,
	input wire [7:0] i_mdata_in,
	output reg [7:0] o_mdata_out,
	output reg o_mdata_oe,
	output reg o_mdtack_out,
	output reg o_mdtack_oe,
	input wire i_cell_tx_clock,
	input wire i_cell_tx_enable_n,
	input wire [4:0] i_cell_tx_port_select,
	input wire [15:0] i_cell_tx_word,
	input wire i_cell_tx_parity,
	input wire i_cell_tx_first_word,
	output reg o_cell_tx_space_flag,
	input wire i_cell_rx_clock,
	input wire i_cell_rx_enable_n,
	input wire [4:0] i_cell_rx_port_select,
	output reg [15:0] o_cell_rx_word,
	output reg o_cell_rx_parity,
	output reg o_cell_rx_first_word,
	output reg o_cell_rx_drive_oe,
	output reg o_cell_rx_ready_flag,
	output reg o_cell_rx_ready_flag_oe,
	output reg [15:0] o_tx_word,
	output reg o_tx_first_word,
	output reg o_tx_valid,
	input wire i_tx_ready,
	input wire [15:0] i_rx_word,
	input wire i_rx_first_word,
	input wire i_rx_valid,
	output reg o_rx_ready
);

////////////////////////////////////////////////////////////////////////////////
// Configuration and status registers.

reg [7:0] parity_cfg;
reg [7:0] io_mode;
reg [7:0] sys_bus;
reg st_tx_perr;
reg st_tx_ovfl;
reg cs_seen;
reg [7:0] next_rd_data;

wire wide_bus_select = io_mode[`UCP_BIT_WIDE_BUS];
wire flow_signal_mode = sys_bus[`UCP_BIT_FLOW_MODE];
wire parity_sense_select = parity_cfg[`UCP_BIT_PARITY_SENSE];
wire [7:0] cell_words = wide_bus_select ? `UCP_CELL_WORDS_16 : `UCP_CELL_WORDS_8;
wire acc_start = !i_mcs_n && !cs_seen;
wire wr_start = acc_start && !i_mwr_n;

reg [`UCP_CNT_W-1:0] tx_count;
reg [`UCP_CNT_W-1:0] rx_count;
reg tx_perr_evt;
reg tx_ovfl_evt;

always @* begin
	case (i_maddr)
	`UCP_ADDR_PARITY_CFG: next_rd_data = parity_cfg;
	`UCP_ADDR_IO_MODE: next_rd_data = io_mode;
	`UCP_ADDR_SYS_BUS: next_rd_data = sys_bus;
	`UCP_ADDR_STATUS: next_rd_data = {4'h0, tx_count == 8'h00, rx_count == 8'h00,
		st_tx_ovfl, st_tx_perr};
	default: next_rd_data = 8'h00;
	endcase
end

// A cycle is taken once per chip-select assertion; acknowledge holds until release.
always @(posedge i_clk) begin
	if (!i_reset_n) begin
		parity_cfg <= `UCP_RST_PARITY_CFG;
		io_mode <= `UCP_RST_IO_MODE;
		sys_bus <= `UCP_RST_SYS_BUS;
		cs_seen <= 1'b0;
		o_mdata_out <= 8'h00;
		o_mdata_oe <= 1'b0;
		o_mdtack_out <= 1'b0;
		o_mdtack_oe <= 1'b0;
	end else begin
		cs_seen <= !i_mcs_n;
		o_mdtack_out <= 1'b0;
		o_mdtack_oe <= cs_seen && !i_mcs_n;
		o_mdata_oe <= !i_mcs_n && !i_moe_n && i_mwr_n;
		if (acc_start && i_mwr_n) begin
			o_mdata_out <= next_rd_data;
		end
		if (wr_start) begin
			case (i_maddr)
			`UCP_ADDR_PARITY_CFG: parity_cfg <= i_mdata_in;
			`UCP_ADDR_IO_MODE: io_mode <= i_mdata_in;
			`UCP_ADDR_SYS_BUS: sys_bus <= i_mdata_in;
			default: parity_cfg <= parity_cfg;
			endcase
		end
	end
end

// Sticky flags clear on a one written; a new event in the same cycle wins.
always @(posedge i_clk) begin
	if (!i_reset_n) begin
		st_tx_perr <= 1'b0;
		st_tx_ovfl <= 1'b0;
	end else begin
		if (tx_perr_evt) begin
			st_tx_perr <= 1'b1;
		end else if (wr_start && i_maddr == `UCP_ADDR_STATUS &&
			i_mdata_in[`UCP_BIT_ST_TX_PERR]) begin
			st_tx_perr <= 1'b0;
		end
		if (tx_ovfl_evt) begin
			st_tx_ovfl <= 1'b1;
		end else if (wr_start && i_maddr == `UCP_ADDR_STATUS &&
			i_mdata_in[`UCP_BIT_ST_TX_OVFL]) begin
			st_tx_ovfl <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Link input synchronisers and link clock edge detection.

reg [24:0] tx_meta;
reg [24:0] tx_sync;
reg tx_clk_last;
reg [6:0] rx_meta;
reg [6:0] rx_sync;
reg rx_clk_last;

always @(posedge i_clk) begin
	if (!i_reset_n) begin
		tx_meta <= 25'h0000000;
		tx_sync <= 25'h0000000;
		tx_clk_last <= 1'b0;
		rx_meta <= 7'h00;
		rx_sync <= 7'h00;
		rx_clk_last <= 1'b0;
	end else begin
		tx_meta <= {i_cell_tx_clock, i_cell_tx_enable_n, i_cell_tx_port_select,
			i_cell_tx_word, i_cell_tx_parity, i_cell_tx_first_word};
		tx_sync <= tx_meta;
		tx_clk_last <= tx_sync[24];
		rx_meta <= {i_cell_rx_clock, i_cell_rx_enable_n, i_cell_rx_port_select};
		rx_sync <= rx_meta;
		rx_clk_last <= rx_sync[6];
	end
end

// All link inputs pass the same two stages, so they stay aligned with the clock edge.
wire tx_edge = tx_sync[24] && !tx_clk_last;
wire tx_en_n = tx_sync[23];
wire [4:0] tx_addr = tx_sync[22:18];
wire [15:0] tx_word = tx_sync[17:2];
wire tx_par = tx_sync[1];
wire tx_first = tx_sync[0];
wire rx_edge = rx_sync[6] && !rx_clk_last;
wire rx_en_n = rx_sync[5];
wire [4:0] rx_addr = rx_sync[4:0];

////////////////////////////////////////////////////////////////////////////////
// Transmit path: link into buffer, buffer out to the framer side.

reg tx_sel;
reg [`UCP_PTR_W-1:0] tx_wptr;
reg [`UCP_PTR_W-1:0] tx_rptr;
wire [`UCP_WORD_W-1:0] tx_rd_data;
wire tx_full = tx_count == `UCP_DEPTH;
wire tx_take = tx_edge && !tx_en_n && tx_sel;
wire tx_wr = tx_take && !tx_full;
wire tx_rd = tx_count != 8'h00 && (!o_tx_valid || i_tx_ready);
wire [15:0] tx_chk_word = wide_bus_select ? tx_word : {8'h00, tx_word[7:0]};
wire tx_par_exp = (^tx_chk_word) ^ parity_sense_select;
wire [`UCP_CNT_W-1:0] tx_free = `UCP_DEPTH - tx_count;

always @(posedge i_clk) begin
	if (!i_reset_n) begin
		tx_sel <= 1'b0;
		tx_wptr <= 7'h00;
		tx_rptr <= 7'h00;
		tx_count <= 8'h00;
		tx_perr_evt <= 1'b0;
		tx_ovfl_evt <= 1'b0;
		o_tx_valid <= 1'b0;
		o_cell_tx_space_flag <= 1'b0;
	end else begin
		// Selection is made on an edge with the enable high; null never matches.
		if (tx_edge && tx_en_n) begin
			tx_sel <= tx_addr != `UCP_NULL_PORT && tx_addr == `UCP_PORT_ADDR;
		end
		tx_perr_evt <= tx_take && tx_par != tx_par_exp;
		// A word that meets a full buffer is dropped and raises the overflow flag; its parity is still checked.
		tx_ovfl_evt <= tx_take && tx_full;
		if (tx_wr) begin
			tx_wptr <= tx_wptr + 7'h01;
		end
		if (tx_rd) begin
			tx_rptr <= tx_rptr + 7'h01;
		end
		if (tx_wr && !tx_rd) begin
			tx_count <= tx_count + 8'h01;
		end else if (tx_rd && !tx_wr) begin
			tx_count <= tx_count - 8'h01;
		end
		if (tx_rd) begin
			o_tx_valid <= 1'b1;
		end else if (i_tx_ready) begin
			o_tx_valid <= 1'b0;
		end
		// Polled address answers for this port only.
		if (tx_addr != `UCP_PORT_ADDR) begin
			o_cell_tx_space_flag <= 1'b0;
		end else if (flow_signal_mode) begin
			o_cell_tx_space_flag <= tx_free >= cell_words;
		end else begin
			o_cell_tx_space_flag <= !tx_full;
		end
	end
end

always @* begin
	o_tx_word = tx_rd_data[15:0];
	o_tx_first_word = tx_rd_data[16];
end

// Word and first-word flag stored together, as received from the link.
ucp_cell_ram #(
	.WIDTH(`UCP_WORD_W),
	.AW(`UCP_PTR_W)
) u_tx_ram (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_wr_en(tx_wr),
	.i_wr_addr(tx_wptr),
	.i_wr_data({tx_first, tx_word}),
	.i_rd_en(tx_rd),
	.i_rd_addr(tx_rptr),
	.o_rd_data(tx_rd_data)
);

////////////////////////////////////////////////////////////////////////////////
// Receive path: framer side into buffer, buffer out to the link.

reg rx_sel;
reg rx_rd_d;
reg [`UCP_PTR_W-1:0] rx_wptr;
reg [`UCP_PTR_W-1:0] rx_rptr;
wire [`UCP_WORD_W-1:0] rx_rd_data;
wire rx_wr = i_rx_valid && o_rx_ready;
// A read strobe on an empty buffer leaves the word and parity outputs unchanged; the first-word output still clears.
wire rx_rd = rx_edge && !rx_en_n && rx_sel && rx_count != 8'h00;
wire [15:0] rx_gen_word = wide_bus_select ? rx_rd_data[15:0] : {8'h00, rx_rd_data[7:0]};

always @(posedge i_clk) begin
	if (!i_reset_n) begin
		rx_sel <= 1'b0;
		rx_rd_d <= 1'b0;
		rx_wptr <= 7'h00;
		rx_rptr <= 7'h00;
		rx_count <= 8'h00;
		o_rx_ready <= 1'b0;
		o_cell_rx_word <= 16'h0000;
		o_cell_rx_parity <= 1'b0;
		o_cell_rx_first_word <= 1'b0;
		o_cell_rx_drive_oe <= 1'b0;
		o_cell_rx_ready_flag <= 1'b0;
		o_cell_rx_ready_flag_oe <= 1'b0;
	end else begin
		if (rx_edge && rx_en_n) begin
			rx_sel <= rx_addr != `UCP_NULL_PORT && rx_addr == `UCP_PORT_ADDR;
		end
		o_cell_rx_drive_oe <= rx_sel;
		rx_rd_d <= rx_rd;
		// Ready drops early so that the lag of this register cannot overfill the buffer.
		o_rx_ready <= rx_count < `UCP_RX_READY_LIMIT;
		if (rx_wr) begin
			rx_wptr <= rx_wptr + 7'h01;
		end
		if (rx_rd) begin
			rx_rptr <= rx_rptr + 7'h01;
		end
		if (rx_wr && !rx_rd) begin
			rx_count <= rx_count + 8'h01;
		end else if (rx_rd && !rx_wr) begin
			rx_count <= rx_count - 8'h01;
		end
		// Output word changes a cycle after the buffer read returns.
		if (rx_rd_d) begin
			o_cell_rx_word <= rx_rd_data[15:0];
			o_cell_rx_parity <= (^rx_gen_word) ^ parity_sense_select;
			o_cell_rx_first_word <= rx_rd_data[16];
		end else if (rx_edge) begin
			o_cell_rx_first_word <= 1'b0;
		end
		// The available flag answers its own polled address whatever port is selected.
		o_cell_rx_ready_flag_oe <= rx_addr == `UCP_PORT_ADDR;
		if (flow_signal_mode) begin
			o_cell_rx_ready_flag <= rx_count >= cell_words;
		end else begin
			o_cell_rx_ready_flag <= rx_count != 8'h00;
		end
	end
end

ucp_cell_ram #(
	.WIDTH(`UCP_WORD_W),
	.AW(`UCP_PTR_W)
) u_rx_ram (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_wr_en(rx_wr),
	.i_wr_addr(rx_wptr),
	.i_wr_data({i_rx_first_word, i_rx_word}),
	.i_rd_en(rx_rd),
	.i_rd_addr(rx_rptr),
	.o_rd_data(rx_rd_data)
);

endmodule

// ===== design/ucp_cell_ram.v
`timescale 1ns/1ns
module ucp_cell_ram #(
	parameter WIDTH = 17,
	parameter AW = 7
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_wr_en,
	input wire [AW-1:0] i_wr_addr,
	input wire [WIDTH-1:0] i_wr_data,
	input wire i_rd_en,
	input wire [AW-1:0] i_rd_addr,
	output reg [WIDTH-1:0] o_rd_data
);

reg [WIDTH-1:0] mem [0:(1<<AW)-1];

always @(posedge i_clk) begin
	if (i_wr_en) begin
		mem[i_wr_addr] <= i_wr_data;
	end
end

always @(posedge i_clk) begin
	if (!i_reset_n) begin
		o_rd_data <= {WIDTH{1'b0}};
	end else if (i_rd_en) begin
		o_rd_data <= mem[i_rd_addr];
	end
end

endmodule

// ===== inc/ucp_defines.vh
`ifndef UCP_DEFINES_VH
`define UCP_DEFINES_VH

// Register offsets on the 14-bit processor address bus.
`define UCP_ADDR_PARITY_CFG 14'h000D
`define UCP_ADDR_STATUS 14'h000E
`define UCP_ADDR_IO_MODE 14'h0202
`define UCP_ADDR_SYS_BUS 14'h0E01

// Reset values.
`define UCP_RST_PARITY_CFG 8'h00
`define UCP_RST_IO_MODE 8'h00
`define UCP_RST_SYS_BUS 8'h00

// Field positions.
`define UCP_BIT_WIDE_BUS 0
`define UCP_BIT_FLOW_MODE 1
`define UCP_BIT_PARITY_SENSE 2
`define UCP_BIT_ST_TX_PERR 0
`define UCP_BIT_ST_TX_OVFL 1
`define UCP_BIT_ST_RX_EMPTY 2
`define UCP_BIT_ST_TX_EMPTY 3

// Multi-PHY addressing.
`define UCP_NULL_PORT 5'h1F
`define UCP_PORT_ADDR 5'h00

// Cell buffers: 128 words of 16 data bits plus a first-word flag.
`define UCP_PTR_W 7
`define UCP_CNT_W 8
`define UCP_DEPTH 8'h80
`define UCP_WORD_W 17
`define UCP_CELL_WORDS_8 8'h35
`define UCP_CELL_WORDS_16 8'h1B
`define UCP_RX_READY_LIMIT 8'h7E

`endif

// ===== verification/ucp_atm_master.sv
`timescale 1ns/1ns
module ucp_atm_master (
	output logic o_tx_clk = 1'b0,
	output logic o_tx_en_n = 1'b1,
	output logic [4:0] o_tx_sel = 5'h1F,
	output logic [15:0] o_tx_word = 16'h0000,
	output logic o_tx_par = 1'b0,
	output logic o_tx_sof = 1'b0,
	output logic o_rx_clk = 1'b0,
	output logic o_rx_en_n = 1'b1,
	output logic [4:0] o_rx_sel = 5'h1F,
	input wire logic [15:0] i_rx_word,
	input wire logic i_rx_sof
);
logic wide = 1'b0;
logic odd = 1'b0;
logic [16:0] got[$];
// Link clocks run only inside a frame; a frame ends with a deselecting edge.
task send(input logic [4:0] a, input int n, input logic [15:0] b, input logic bad);
	logic [15:0] w;
	#13;
	for (int i = -1; i <= n; i++) begin
		w = b + 16'(i) * 16'h0101;
		o_tx_en_n = !(i >= 0 && i < n);
		o_tx_sel = (i < n) ? a : 5'h1F;
		o_tx_sof = (i == 0);
		o_tx_word = o_tx_en_n ? ~o_tx_word : w;
		o_tx_par = (wide ? ^w : ^w[7:0]) ^ odd ^ (bad && i == 0);
		#400 o_tx_clk = 1'b1;
		#400 o_tx_clk = 1'b0;
	end
endtask
task recv(input logic [4:0] a, input int n);
	got.delete();
	#13;
	for (int i = -1; i <= n + 1; i++) begin
		o_rx_en_n = !(i >= 0 && i < n);
		o_rx_sel = (i <= n) ? a : 5'h1F;
		#400 o_rx_clk = 1'b1;
		if (i >= 1 && i <= n) got.push_back({i_rx_sof, i_rx_word});
		#400 o_rx_clk = 1'b0;
	end
endtask
task poll(input logic [4:0] t, input logic [4:0] r);
	o_tx_sel = t;
	o_rx_sel = r;
endtask
endmodule

// ===== verification/ucp_cell_port_sva.sv
`timescale 1ns/1ns
module ucp_cell_port_sva (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_mcs_n,
	input wire i_mwr_n,
	input wire [13:0] i_maddr,
	input wire [7:0] i_mdata_in,
	input wire o_mdtack_out,
	input wire o_mdtack_oe,
	input wire i_cell_tx_enable_n,
	input wire [4:0] i_cell_tx_port_select,
	input wire o_cell_tx_space_flag,
	input wire i_cell_rx_enable_n,
	input wire [4:0] i_cell_rx_port_select,
	input wire [15:0] o_cell_rx_word,
	input wire o_cell_rx_parity,
	input wire o_cell_rx_first_word,
	input wire o_cell_rx_drive_oe,
	input wire o_cell_rx_ready_flag_oe,
	input wire o_tx_valid
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
// Shadow copies of the width and sense bits, and cycle counters for the link strobes.
reg wide;
reg odd;
reg [4:0] tx_idle;
reg [4:0] rx_idle;
reg [4:0] nul_cnt;
reg [4:0] sof_cnt;
always @(posedge i_clk) begin
	if (!i_reset_n) begin
		wide <= 1'b0;
		odd <= 1'b0;
		tx_idle <= 5'h00;
		rx_idle <= 5'h00;
		nul_cnt <= 5'h00;
		sof_cnt <= 5'h00;
	end else begin
		if (!i_mcs_n && !i_mwr_n && i_maddr == 14'h0202) wide <= i_mdata_in[0];
		if (!i_mcs_n && !i_mwr_n && i_maddr == 14'h000D) odd <= i_mdata_in[2];
		tx_idle <= i_cell_tx_enable_n ? tx_idle + {4'h0, tx_idle != 5'h1F} : 5'h00;
		rx_idle <= i_cell_rx_enable_n ? rx_idle + {4'h0, rx_idle != 5'h1F} : 5'h00;
		nul_cnt <= (i_cell_rx_port_select == 5'h1F && i_cell_rx_enable_n) ?
			nul_cnt + {4'h0, nul_cnt != 5'h1F} : 5'h00;
		sof_cnt <= o_cell_rx_first_word ? sof_cnt + {4'h0, sof_cnt != 5'h1F} : 5'h00;
	end
end
ack_timing_a:
	assert property (!i_mcs_n && $past(i_mcs_n) |-> ##2 o_mdtack_oe) else $error("late ack");
ack_drive_a:
	assert property (o_mdtack_oe |-> !o_mdtack_out) else $error("ack level wrong");
tx_null_a:
	assert property (i_cell_tx_port_select == 5'h1F [*6] |-> !o_cell_tx_space_flag)
		else $error("tx flag on null port");
rx_null_a:
	assert property (i_cell_rx_port_select == 5'h1F [*6] |-> !o_cell_rx_ready_flag_oe)
		else $error("rx flag on null port");
rx_unsel_a:
	assert property (nul_cnt > 5'h10 |-> !o_cell_rx_drive_oe) else $error("rx driven unselected");
rx_parity_a:
	assert property ($changed(o_cell_rx_word) |->
		o_cell_rx_parity == ((wide ? ^o_cell_rx_word : ^o_cell_rx_word[7:0]) ^ odd))
		else $error("rx parity wrong");
rx_enable_a:
	assert property ($changed(o_cell_rx_word) |-> rx_idle < 5'h0A)
		else $error("rx word without enable");
rx_first_a:
	assert property (o_cell_rx_first_word |-> sof_cnt < 5'h0A) else $error("rx first word too long");
tx_enable_a:
	assert property ($rose(o_tx_valid) |-> tx_idle < 5'h0A) else $error("tx word without enable");
endmodule
bind ucp_cell_port ucp_cell_port_sva chk_i (.*);

// ===== verification/ucp_cell_port_tb_top.sv
`timescale 1ns/1ns
module ucp_cell_port_tb_top;
logic i_clk = 1'b0, i_reset_n = 1'b0, i_mcs_n = 1'b1, i_mwr_n = 1'b1, i_moe_n = 1'b1;
logic i_tx_ready = 1'b1;
logic i_rx_first_word = 1'b0, i_rx_valid = 1'b0;
logic [13:0] i_maddr = 14'h0000;
logic [7:0] i_mdata_in = 8'h00;
logic [15:0] i_rx_word = 16'h0000;
wire [7:0] o_mdata_out;
wire [15:0] o_cell_rx_word, o_tx_word, i_cell_tx_word;
wire [4:0] i_cell_tx_port_select, i_cell_rx_port_select;
wire o_mdata_oe, o_mdtack_out, o_mdtack_oe, o_cell_tx_space_flag, o_cell_rx_parity;
wire o_cell_rx_first_word, o_cell_rx_drive_oe, o_cell_rx_ready_flag, o_cell_rx_ready_flag_oe;
wire o_tx_first_word, o_tx_valid, o_rx_ready, i_cell_tx_clock, i_cell_tx_enable_n;
wire i_cell_tx_parity, i_cell_tx_first_word, i_cell_rx_clock, i_cell_rx_enable_n;
wire [2:0] flags = {o_cell_tx_space_flag, o_cell_rx_ready_flag_oe, o_cell_rx_ready_flag};
int checks = 0;
int fail_count = 0;
logic [16:0] txq[$];
ucp_cell_port uut (.*);
ucp_atm_master atm (.o_tx_clk(i_cell_tx_clock), .o_tx_en_n(i_cell_tx_enable_n),
	.o_tx_sel(i_cell_tx_port_select), .o_tx_word(i_cell_tx_word), .o_tx_par(i_cell_tx_parity),
	.o_tx_sof(i_cell_tx_first_word), .o_rx_clk(i_cell_rx_clock), .o_rx_en_n(i_cell_rx_enable_n),
	.o_rx_sel(i_cell_rx_port_select),
	// Released receive pins: data lines show the inverse, first-word falls to its pull-down.
	.i_rx_word(o_cell_rx_drive_oe ? o_cell_rx_word : ~o_cell_rx_word),
	.i_rx_sof(o_cell_rx_drive_oe && o_cell_rx_first_word));
always #50 i_clk = ~i_clk;
always @(posedge i_clk) if (o_tx_valid === 1'b1) txq.push_back({o_tx_first_word, o_tx_word});
task chk(input string n, input logic [16:0] e, input logic [16:0] s);
	checks++;
	if (s !== e) begin
		fail_count++;
		$display("[FAIL] %s expected %h seen %h", n, e, s);
	end
endtask
task bus(input logic wrn, input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
	int n;
	n = 0;
	@(negedge i_clk);
	{i_mcs_n, i_mwr_n, i_moe_n, i_maddr, i_mdata_in} = {1'b0, wrn, !wrn, a, d};
	while (o_mdtack_oe !== 1'b1 && n < 20) begin
		@(negedge i_clk);
		n++;
	end
	q = o_mdata_out;
	chk("ack", 17'h1, o_mdtack_oe);
	chk("data_oe", wrn, o_mdata_oe);
	{i_mcs_n, i_mwr_n, i_moe_n} = 3'b111;
	@(negedge i_clk);
endtask
task rd(input logic [13:0] a, output logic [7:0] q);
	bus(1'b1, a, 8'h00, q);
endtask
task wr(input logic [13:0] a, input logic [7:0] d);
	logic [7:0] q;
	bus(1'b0, a, d, q);
endtask
task cfg(input logic w, input logic o, input logic c);
	wr(14'h0202, {7'h00, w});
	wr(14'h000D, {5'h00, o, 2'b00});
	wr(14'h0E01, {6'h00, c, 1'b0});
	atm.wide = w;
	atm.odd = o;
endtask
task push(input logic [15:0] w, input logic f);
	@(negedge i_clk);
	chk("rx_ready", 17'h1, o_rx_ready);
	{i_rx_word, i_rx_first_word, i_rx_valid} = {w, f, 1'b1};
	@(negedge i_clk);
	i_rx_valid = 1'b0;
endtask
task automatic t_regs;
	logic [7:0] q;
	logic [13:0] ad[5] = '{14'h000D, 14'h0202, 14'h0E01, 14'h0123, 14'h000E};
	logic [7:0] ex[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C};
	for (int k = 0; k < 5; k++) begin
		rd(ad[k], q);
		chk("reg_reset", ex[k], q);
	end
	wr(14'h000D, 8'h04);
	rd(14'h000D, q);
	chk("parity_cfg", 17'h04, q);
	$display("register test done");
endtask
task t_tx(input logic w, input logic o);
	logic [7:0] q;
	logic [15:0] m;
	m = w ? 16'hFFFF : 16'h00FF;
	cfg(w, o, 1'b0);
	txq.delete();
	atm.send(5'h00, 4, 16'h5AC3, 1'b0);
	atm.send(5'h1F, 2, 16'h1234, 1'b0);
	repeat (10) @(negedge i_clk);
	chk("tx_count", 17'h4, 17'(txq.size()));
	for (int k = 0; k < 4; k++)
		chk("tx_word", {k == 0, (16'h5AC3 + 16'(k) * 16'h0101) & m}, txq[k] & {1'b1, m});
	rd(14'h000E, q);
	chk("tx_status", 17'h0, q & 8'h03);
	atm.send(5'h00, 1, 16'h0F0F, 1'b1);
	rd(14'h000E, q);
	chk("tx_perr", 17'h1, q & 8'h03);
	wr(14'h000E, 8'h01);
	$display("tx test done");
endtask
task t_rx(input logic w, input logic o);
	logic [15:0] m;
	m = w ? 16'hFFFF : 16'h00FF;
	cfg(w, o, 1'b0);
	for (int k = 0; k < 3; k++)
		push(16'h81E7 + 16'(k) * 16'h0202, k == 0);
	atm.recv(5'h00, 4);
	for (int k = 0; k < 4; k++)
		chk("rx_word", {k == 0, (16'h81E7 + 16'(k < 3 ? k : 2) * 16'h0202) & m},
			atm.got[k] & {1'b1, m});
	$display("rx test done");
endtask
task t_flag;
	cfg(1'b1, 1'b0, 1'b1);
	push(16'h7E11, 1'b1);
	atm.poll(5'h00, 5'h00);
	repeat (10) @(negedge i_clk);
	chk("flags_cell", 17'h6, flags);
	for (int k = 0; k < 25; k++)
		push(16'h0000, 1'b0);
	repeat (4) @(negedge i_clk);
	chk("flags_cell_26", 17'h6, flags);
	push(16'h0000, 1'b0);
	repeat (4) @(negedge i_clk);
	chk("flags_cell_27", 17'h7, flags);
	wr(14'h0E01, 8'h00);
	repeat (4) @(negedge i_clk);
	chk("flags_word", 17'h7, flags);
	atm.poll(5'h1F, 5'h1F);
	atm.recv(5'h00, 1);
	chk("flag_drain", {1'b1, 16'h7E11}, atm.got[0]);
	$display("flag test done");
endtask
task summarize;
	$display("checks %0d mismatches %0d", checks, fail_count);
	if (fail_count == 0 && checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
initial begin
	repeat (8) @(negedge i_clk);
	i_reset_n = 1'b1;
	repeat (4) @(negedge i_clk);
	t_regs();
	t_tx(1'b0, 1'b0);
	t_tx(1'b1, 1'b1);
	t_rx(1'b0, 1'b1);
	t_rx(1'b1, 1'b0);
	t_flag();
	summarize();
end
initial begin
	#500000;
	fail_count++;
	summarize();
end
endmodule
